/* File: hw/asc_defs.svh */
/*
 Constants for the active/standby changeover link: widths, timing, codes.
 Assumes a single 10 MHz clock shared by both ends of the link.
*/
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

`define ASC_TYPE_W 4
`define ASC_PAIR_W 4
`define ASC_CFG_W 8
`define ASC_COD_W 8
`define ASC_TMR_W 10

// Clock period and sequence times in ns
`define ASC_CLK_NS 100
`define ASC_COD_NS 1000
`define ASC_TEST_NS 100000

`define ASC_SLOT_PRI 1'b0
`define ASC_SLOT_SEC 1'b1
`define ASC_SLICES 3

`endif

/* File: hw/asc_pkg.sv */
/*
 Types shared by the supervisor end and the module end.
 Assumes asc_defs.svh is on the include path.
*/
`include "asc_defs.svh"

package asc_pkg;

    typedef enum logic [1:0] {
        ROLE_OFFLINE,
        ROLE_STANDBY,
        ROLE_MAINTAIN,
        ROLE_ACTIVE
    } asc_role_t;

    typedef enum logic [1:0] {
        CLR_OFF,
        CLR_GREEN,
        CLR_RED,
        CLR_AMBER
    } asc_color_t;

    typedef struct packed {
        asc_color_t color;
        logic flash;
    } asc_ind_t;

endpackage

/* File: hw/asc_link_if.sv */
/*
 Link between the changeover supervisor and one redundant I/O module.
 Assumes both ends run on the same clock; no clocking here.
*/
`timescale 1ns/10ps
`include "asc_defs.svh"

interface asc_link_if;
    // Supervisor to module
    asc_pkg::asc_role_t role;
    logic cfg_valid;
    logic [`ASC_CFG_W-1:0] cfg_word;
    logic cod_valid;
    logic [`ASC_COD_W-1:0] cod_word_in;
    logic cod_xfer;
    logic changeover;
    logic energise;
    // Module to supervisor
    logic seated;
    logic [`ASC_TYPE_W-1:0] type_code;
    logic [`ASC_PAIR_W-1:0] pair_id;
    logic sw_closed;
    logic sw_open;
    logic fault;
    logic shut;
    logic configured;
    logic selftest_ok;
    logic [`ASC_COD_W-1:0] cod_word_out;

    modport supervisor (
        output role, cfg_valid, cfg_word, cod_valid, cod_word_in, cod_xfer,
        output changeover, energise,
        input seated, type_code, pair_id, sw_closed, sw_open, fault, shut,
        input configured, selftest_ok, cod_word_out
    );

    modport module_end (
        input role, cfg_valid, cfg_word, cod_valid, cod_word_in, cod_xfer,
        input changeover, energise,
        output seated, type_code, pair_id, sw_closed, sw_open, fault, shut,
        output configured, selftest_ok, cod_word_out
    );
endinterface

/* File: hw/asc_module_end.sv */
/*
 One redundant I/O module: follows the role given by the supervisor,
 latches shutdown, holds configuration, drives indicators and outputs.
 Assumes seated and removal-switch pins are asynchronous.
*/
`timescale 1ns/10ps
`include "asc_defs.svh"

module asc_module_end (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    asc_link_if.module_end lnk,
    input wire logic i_seated,
    input wire logic i_sw_a_closed,
    input wire logic i_sw_b_closed,
    input wire logic [`ASC_TYPE_W-1:0] i_type_code,
    input wire logic [`ASC_PAIR_W-1:0] i_pair_id,
    input wire logic i_fault,
    input wire logic [`ASC_SLICES-1:0] i_slice_fault,
    input wire logic i_shutdown_req,
    input wire logic i_selftest_pass,
    input wire logic [`ASC_COD_W-1:0] i_cod_word,
    output asc_pkg::asc_ind_t o_health_ind [`ASC_SLICES],
    output asc_pkg::asc_ind_t o_active_ind,
    output asc_pkg::asc_ind_t o_standby_ind,
    output asc_pkg::asc_ind_t o_config_ind,
    output logic o_energised,
    output logic o_field_test_en,
    output logic [`ASC_CFG_W-1:0] o_cfg_word,
    output logic [`ASC_COD_W-1:0] o_cod_word
);

    function automatic asc_pkg::asc_ind_t mk_ind(input asc_pkg::asc_color_t c,
                                                 input logic f);
        asc_pkg::asc_ind_t r;
        r.color = c;
        r.flash = f;
        return r;
    endfunction

    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic seated;
    logic shut_reg;
    logic configured_reg;
    logic is_active;

    assign seated = pin_sync_reg[0];
    assign is_active = (lnk.role == asc_pkg::ROLE_ACTIVE);

    // Pin synchronisers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else if (i_ce) begin
            pin_meta_reg <= {i_sw_b_closed, i_sw_a_closed, i_seated};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Shutdown latch, cleared only by removal
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shut_reg <= 1'b0;
        end else if (i_ce) begin
            if (!seated) begin
                shut_reg <= 1'b0;
            end else if (i_shutdown_req) begin
                shut_reg <= 1'b1;
            end
        end
    end

    // Configuration and changeover data
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            configured_reg <= 1'b0;
            o_cfg_word <= '0;
            o_cod_word <= '0;
        end else if (i_ce) begin
            if (!seated || shut_reg) begin
                configured_reg <= 1'b0;
            end else if (lnk.cfg_valid) begin
                configured_reg <= 1'b1;
                o_cfg_word <= lnk.cfg_word;
            end
            if (lnk.cod_valid && !shut_reg) begin
                o_cod_word <= lnk.cod_word_in;
            end
        end
    end

    // Output energising and field loop testing
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_energised <= 1'b0;
            o_field_test_en <= 1'b0;
        end else if (i_ce) begin
            o_energised <= is_active && lnk.energise && configured_reg && !shut_reg;
            o_field_test_en <= configured_reg && !shut_reg &&
                               (lnk.role == asc_pkg::ROLE_ACTIVE ||
                                lnk.role == asc_pkg::ROLE_STANDBY);
        end
    end

    // Front-panel indicators
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < `ASC_SLICES; i++) begin
                o_health_ind[i] <= mk_ind(asc_pkg::CLR_OFF, 1'b0);
            end
            o_active_ind <= mk_ind(asc_pkg::CLR_OFF, 1'b0);
            o_standby_ind <= mk_ind(asc_pkg::CLR_OFF, 1'b0);
            o_config_ind <= mk_ind(asc_pkg::CLR_OFF, 1'b0);
        end else if (i_ce) begin
            for (int i = 0; i < `ASC_SLICES; i++) begin
                if (shut_reg) begin
                    o_health_ind[i] <= mk_ind(asc_pkg::CLR_RED, 1'b0);
                end else if (i_slice_fault[i]) begin
                    o_health_ind[i] <= mk_ind(asc_pkg::CLR_RED, 1'b1);
                end else begin
                    o_health_ind[i] <= mk_ind(asc_pkg::CLR_GREEN, 1'b0);
                end
            end
            if (shut_reg) begin
                o_active_ind <= mk_ind(asc_pkg::CLR_RED, 1'b1);
                o_standby_ind <= mk_ind(asc_pkg::CLR_RED, 1'b1);
                o_config_ind <= mk_ind(asc_pkg::CLR_AMBER, 1'b1);
            end else begin
                if (lnk.changeover) begin
                    o_active_ind <= mk_ind(asc_pkg::CLR_AMBER, 1'b1);
                    o_standby_ind <= mk_ind(asc_pkg::CLR_AMBER, 1'b1);
                end else begin
                    if (is_active && lnk.energise) begin
                        o_active_ind <= mk_ind(asc_pkg::CLR_GREEN, 1'b0);
                    end else if (configured_reg &&
                                 (is_active || lnk.role == asc_pkg::ROLE_OFFLINE)) begin
                        o_active_ind <= mk_ind(asc_pkg::CLR_RED, 1'b1);
                    end else begin
                        o_active_ind <= mk_ind(asc_pkg::CLR_OFF, 1'b0);
                    end
                    if (lnk.role == asc_pkg::ROLE_STANDBY ||
                        lnk.role == asc_pkg::ROLE_MAINTAIN) begin
                        o_standby_ind <= mk_ind(asc_pkg::CLR_GREEN, 1'b0);
                    end else begin
                        o_standby_ind <= mk_ind(asc_pkg::CLR_OFF, 1'b0);
                    end
                end
                if (lnk.cod_xfer) begin
                    o_config_ind <= mk_ind(asc_pkg::CLR_AMBER, 1'b1);
                end else if (configured_reg) begin
                    o_config_ind <= mk_ind(asc_pkg::CLR_GREEN, 1'b0);
                end else begin
                    o_config_ind <= mk_ind(asc_pkg::CLR_OFF, 1'b0);
                end
            end
        end
    end

    // Status towards the supervisor
    assign lnk.seated = seated;
    assign lnk.type_code = i_type_code;
    assign lnk.pair_id = i_pair_id;
    assign lnk.sw_closed = pin_sync_reg[1] & pin_sync_reg[2];
    assign lnk.sw_open = ~pin_sync_reg[1] & ~pin_sync_reg[2];
    assign lnk.fault = seated & i_fault;
    assign lnk.shut = shut_reg;
    assign lnk.configured = configured_reg;
    assign lnk.selftest_ok = i_selftest_pass & ~shut_reg & configured_reg;
    assign lnk.cod_word_out = i_cod_word;

endmodule

/* File: hw/asc_supervisor.sv */
/*
 Changeover supervisor for one module pair: picks the Active module,
 educates modules, runs the changeover sequence and reverts on failure.
 Assumes the primary link on lnk_pri, the spare link on lnk_sec, and a
 reset push button on an asynchronous pin.
*/
// Behaviour
// - Primary normally Active, secondary normally Standby; here the secondary stays Offline until a changeover attempt makes it Standby
// - Fault moves control to fitted spare automatically
// - Without spare, keep running on Active module
// - Shut module: health red, roles red flash
// - Shutdown cleared only by removal and reinsertion
// - Outputs energise only after reset button press
// - At startup primary becomes Active if installed
// - Else dedicated secondary becomes Active
// - Shared secondary never Active at startup
// - Check type and switches, configure, then Active
// - Active reports fault; changeover attempt begins
// - No Standby: keep Active, keep polling
// - Check candidate type, switches and pair link
// - Copy configuration to candidate, make it Standby
// - Active to Maintain, then transfer changeover data
// - Config indicator flashes amber during data transfer
// - Standby becomes Active, old Active becomes Standby
// - Self-test failure reverts both roles
// - Both switches open on Active requests changeover
// - Changeover only onto fault-free module normally
// - Open switches plus reset button forces changeover
// - Status indicator flashes amber during changeover
`timescale 1ns/10ps
`include "asc_defs.svh"

module asc_supervisor #(
    parameter int TEST_NS = `ASC_TEST_NS
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    asc_link_if.supervisor lnk_pri,
    asc_link_if.supervisor lnk_sec,
    input wire logic i_reset_btn,
    input wire logic i_sec_defined,
    input wire logic i_sec_shared,
    input wire logic [`ASC_TYPE_W-1:0] i_type_code,
    input wire logic [`ASC_PAIR_W-1:0] i_pair_id,
    input wire logic [`ASC_CFG_W-1:0] i_cfg_word,
    output logic o_sys_health,
    output logic o_active_slot,
    output logic o_active_valid,
    output logic o_changeover
);

    localparam int COD_CYC = `ASC_COD_NS / `ASC_CLK_NS;
    localparam int TEST_CYC = TEST_NS / `ASC_CLK_NS;

    typedef enum logic [3:0] {
        S_BOOT,
        S_SELECT,
        S_EDUCATE,
        S_RUN,
        S_SEEK,
        S_LOAD,
        S_MAINT,
        S_COD,
        S_TEST
    } asc_state_t;

    function automatic logic link_ok(input logic seated,
                                     input logic [`ASC_TYPE_W-1:0] code,
                                     input logic [`ASC_TYPE_W-1:0] want,
                                     input logic closed,
                                     input logic shut);
        return seated && (code == want) && closed && !shut;
    endfunction

    asc_state_t state_reg;
    logic act_reg;
    logic oth;
    asc_pkg::asc_role_t role_reg [2];
    logic [1:0] cfg_pulse_reg;
    logic [1:0] cod_pulse_reg;
    logic [`ASC_COD_W-1:0] cod_word_reg;
    logic [`ASC_TMR_W-1:0] tmr_reg;
    logic tmr_done;
    logic btn_meta_reg;
    logic btn_sync_reg;
    logic btn_last_reg;
    logic press;
    logic energise_reg;
    logic force_reg;
    logic busy;
    logic req;
    logic [1:0] ok;
    logic [1:0] seat;
    logic [1:0] fault;
    logic [1:0] sw_open;
    logic [1:0] cfgd;
    logic [1:0] tested;
    logic [1:0] pair_ok;
    logic [`ASC_COD_W-1:0] act_cod;

    assign oth = ~act_reg;
    assign ok[0] = link_ok(lnk_pri.seated, lnk_pri.type_code, i_type_code,
                           lnk_pri.sw_closed, lnk_pri.shut);
    assign ok[1] = link_ok(lnk_sec.seated, lnk_sec.type_code, i_type_code,
                           lnk_sec.sw_closed, lnk_sec.shut);
    assign seat = {lnk_sec.seated, lnk_pri.seated};
    assign fault = {lnk_sec.fault, lnk_pri.fault};
    assign sw_open = {lnk_sec.sw_open, lnk_pri.sw_open};
    assign cfgd = {lnk_sec.configured, lnk_pri.configured};
    assign tested = {lnk_sec.selftest_ok, lnk_pri.selftest_ok};
    assign pair_ok = {lnk_sec.pair_id == i_pair_id, lnk_pri.pair_id == i_pair_id};
    assign act_cod = act_reg ? lnk_sec.cod_word_out : lnk_pri.cod_word_out;
    assign req = fault[act_reg] | sw_open[act_reg];
    assign busy = (state_reg == S_MAINT) || (state_reg == S_COD) ||
                  (state_reg == S_TEST);
    assign tmr_done = (tmr_reg == '0);
    assign press = btn_sync_reg & ~btn_last_reg;

    // Pair sequencing and role bookkeeping
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= S_BOOT;
            act_reg <= `ASC_SLOT_PRI;
            role_reg[0] <= asc_pkg::ROLE_OFFLINE;
            role_reg[1] <= asc_pkg::ROLE_OFFLINE;
            cfg_pulse_reg <= 2'h0;
            cod_pulse_reg <= 2'h0;
            cod_word_reg <= '0;
        end else if (i_ce) begin
            cfg_pulse_reg <= 2'h0;
            cod_pulse_reg <= 2'h0;
            unique case (state_reg)
                S_BOOT: begin
                    state_reg <= S_SELECT;
                end
                S_SELECT: begin
                    if (ok[0]) begin
                        act_reg <= `ASC_SLOT_PRI;
                        cfg_pulse_reg[0] <= 1'b1;
                        state_reg <= S_EDUCATE;
                    end else if (ok[1] && i_sec_defined && !i_sec_shared) begin
                        act_reg <= `ASC_SLOT_SEC;
                        cfg_pulse_reg[1] <= 1'b1;
                        state_reg <= S_EDUCATE;
                    end
                end
                S_EDUCATE: begin
                    if (!ok[act_reg]) begin
                        state_reg <= S_SELECT;
                    end else if (cfgd[act_reg]) begin
                        role_reg[act_reg] <= asc_pkg::ROLE_ACTIVE;
                        state_reg <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (!seat[oth]) begin
                        role_reg[oth] <= asc_pkg::ROLE_OFFLINE;
                    end
                    if (!seat[act_reg]) begin
                        role_reg[act_reg] <= asc_pkg::ROLE_OFFLINE;
                        state_reg <= S_SELECT;
                    end else if (req) begin
                        state_reg <= S_SEEK;
                    end
                end
                S_SEEK: begin
                    if (!seat[oth]) begin
                        role_reg[oth] <= asc_pkg::ROLE_OFFLINE;
                    end
                    if (!seat[act_reg]) begin
                        role_reg[act_reg] <= asc_pkg::ROLE_OFFLINE;
                        state_reg <= S_SELECT;
                    end else if (!req) begin
                        state_reg <= S_RUN;
                    end else if (ok[oth] && pair_ok[oth]) begin
                        cfg_pulse_reg[oth] <= 1'b1;
                        state_reg <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    if (!ok[oth]) begin
                        state_reg <= S_SEEK;
                    end else if (cfgd[oth]) begin
                        role_reg[oth] <= asc_pkg::ROLE_STANDBY;
                        state_reg <= S_MAINT;
                    end
                end
                S_MAINT: begin
                    role_reg[act_reg] <= asc_pkg::ROLE_MAINTAIN;
                    cod_word_reg <= act_cod;
                    cod_pulse_reg[oth] <= 1'b1;
                    state_reg <= S_COD;
                end
                S_COD: begin
                    if (tmr_done) begin
                        if (!fault[oth] || force_reg) begin
                            role_reg[oth] <= asc_pkg::ROLE_ACTIVE;
                            act_reg <= oth;
                            state_reg <= S_TEST;
                        end else begin
                            role_reg[act_reg] <= asc_pkg::ROLE_ACTIVE;
                            state_reg <= S_SEEK;
                        end
                    end
                end
                S_TEST: begin
                    if (tested[act_reg]) begin
                        role_reg[oth] <= asc_pkg::ROLE_STANDBY;
                        state_reg <= S_RUN;
                    end else if (tmr_done) begin
                        role_reg[act_reg] <= asc_pkg::ROLE_STANDBY;
                        role_reg[oth] <= asc_pkg::ROLE_ACTIVE;
                        act_reg <= oth;
                        state_reg <= S_RUN;
                    end
                end
            endcase
        end
    end

    // Data transfer and self-test timer
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tmr_reg <= '0;
        end else if (i_ce) begin
            if (state_reg == S_MAINT) begin
                tmr_reg <= `ASC_TMR_W'(COD_CYC - 1);
            end else if (state_reg == S_COD && tmr_done) begin
                tmr_reg <= `ASC_TMR_W'(TEST_CYC - 1);
            end else if (!tmr_done) begin
                tmr_reg <= tmr_reg - `ASC_TMR_W'(1);
            end
        end
    end

    // Reset button, energise and forced changeover
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            btn_meta_reg <= 1'b0;
            btn_sync_reg <= 1'b0;
            btn_last_reg <= 1'b0;
            energise_reg <= 1'b0;
            force_reg <= 1'b0;
        end else if (i_ce) begin
            btn_meta_reg <= i_reset_btn;
            btn_sync_reg <= btn_meta_reg;
            btn_last_reg <= btn_sync_reg;
            if (state_reg == S_SELECT) begin
                energise_reg <= 1'b0;
            end else if (press && state_reg != S_EDUCATE && state_reg != S_BOOT) begin
                energise_reg <= 1'b1;
            end
            if (press && sw_open[act_reg] &&
                (state_reg == S_SEEK || state_reg == S_LOAD ||
                 state_reg == S_MAINT || state_reg == S_COD)) begin
                force_reg <= 1'b1;
            end else if (state_reg == S_RUN || state_reg == S_SELECT) begin
                force_reg <= 1'b0;
            end
        end
    end

    assign lnk_pri.role = role_reg[0];
    assign lnk_sec.role = role_reg[1];
    assign lnk_pri.cfg_valid = cfg_pulse_reg[0];
    assign lnk_sec.cfg_valid = cfg_pulse_reg[1];
    assign lnk_pri.cfg_word = i_cfg_word;
    assign lnk_sec.cfg_word = i_cfg_word;
    assign lnk_pri.cod_valid = cod_pulse_reg[0];
    assign lnk_sec.cod_valid = cod_pulse_reg[1];
    assign lnk_pri.cod_word_in = cod_word_reg;
    assign lnk_sec.cod_word_in = cod_word_reg;
    assign lnk_pri.cod_xfer = (state_reg == S_COD);
    assign lnk_sec.cod_xfer = (state_reg == S_COD);
    assign lnk_pri.changeover = busy;
    assign lnk_sec.changeover = busy;
    assign lnk_pri.energise = energise_reg;
    assign lnk_sec.energise = energise_reg;

    assign o_sys_health = energise_reg;
    assign o_active_slot = act_reg;
    assign o_active_valid = (role_reg[act_reg] == asc_pkg::ROLE_ACTIVE);
    assign o_changeover = busy;

endmodule

/* File: test/asc_link_monitor.sv */
/* Checks on one changeover link; its signals arrive as plain inputs on one clock. */
`timescale 1ns/10ps
module asc_link_monitor (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire asc_pkg::asc_role_t role,
    input wire logic seated,
    input wire logic cfg_valid,
    input wire logic configured,
    input wire logic cod_xfer,
    input wire logic changeover,
    input wire logic energise,
    input wire logic shut
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    a_cfg_then_conf: assert property (cfg_valid |=> configured)
        else $error("no config after pulse");
    a_active_conf: assert property (
        $rose(role == asc_pkg::ROLE_ACTIVE) |-> configured) else $error("active unconfigured");
    a_cod_ten_cyc: assert property (
        $rose(cod_xfer) |-> cod_xfer [*8] ##1 cod_xfer ##1 cod_xfer ##1 !cod_xfer)
        else $error("transfer length");
    a_cod_in_cx: assert property (cod_xfer |-> changeover)
        else $error("transfer outside changeover");
    a_maint_in_cx: assert property (
        role == asc_pkg::ROLE_MAINTAIN |-> changeover) else $error("maintain outside");
    a_cx_leaves_act: assert property (
        $rose(changeover) |-> ##[0:1] role != asc_pkg::ROLE_ACTIVE) else $error("active kept");
    a_shut_hold: assert property ($fell(shut) |-> !seated || !$past(seated))
        else $error("shutdown cleared while seated");
    a_energise_act: assert property (
        $rose(energise) |-> role == asc_pkg::ROLE_ACTIVE) else $error("energise not active");
endmodule

/* File: test/active_standby_changeover_tb_top.sv */
/* Bench for supervisor, two links and two modules; one 10 MHz clock. */
`timescale 1ns/10ps
module active_standby_changeover_tb_top;
    localparam logic [2:0] RF = {asc_pkg::CLR_RED, 1'b1}, RS = {asc_pkg::CLR_RED, 1'b0};
    localparam logic [2:0] GS = {asc_pkg::CLR_GREEN, 1'b0}, AF = {asc_pkg::CLR_AMBER, 1'b1};
    localparam logic [1:0] RA = asc_pkg::ROLE_ACTIVE, RM = asc_pkg::ROLE_MAINTAIN;
    localparam logic [1:0] RB = asc_pkg::ROLE_STANDBY;
    logic i_clk, i_rst_b, ce, btn, hl, slot, cx, av;
    logic [1:0] seat, swa, swb, flt, sd, stp, en, ft;
    logic [2:0] slf;
    logic [3:0] ty, pid;
    logic [7:0] cfg, changeover_state_data, dw[2], cw[2];
    asc_pkg::asc_ind_t ai[2], ci[2], si[2], hi[2][3];
    int bad_count, comparisons;
    asc_link_if lk[2] ();
    asc_supervisor #(.TEST_NS(2000)) asc_supervisor_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_ce(ce), .lnk_pri(lk[0]), .lnk_sec(lk[1]), .i_reset_btn(btn), .i_sec_defined(1'b1),
        .i_sec_shared(1'b0), .i_type_code(ty), .i_pair_id(pid), .i_cfg_word(cfg),
        .o_sys_health(hl), .o_active_slot(slot), .o_active_valid(av), .o_changeover(cx));
    for (genvar k = 0; k < 2; k++) begin : g
        asc_module_end asc_module_end_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce),
            .lnk(lk[k]), .i_seated(seat[k]), .i_sw_a_closed(swa[k]), .i_sw_b_closed(swb[k]),
            .i_type_code(ty), .i_pair_id(pid), .i_fault(flt[k]), .i_slice_fault(slf),
            .i_shutdown_req(sd[k]), .i_selftest_pass(stp[k]), .i_cod_word(changeover_state_data),
            .o_health_ind(hi[k]), .o_active_ind(ai[k]), .o_standby_ind(si[k]),
            .o_config_ind(ci[k]), .o_energised(en[k]), .o_field_test_en(ft[k]),
            .o_cfg_word(cw[k]), .o_cod_word(dw[k]));
    end
    asc_link_monitor asc_link_monitor_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .role(lk[0].role),
        .seated(lk[0].seated), .cfg_valid(lk[0].cfg_valid), .configured(lk[0].configured),
        .cod_xfer(lk[0].cod_xfer), .changeover(lk[0].changeover), .energise(lk[0].energise),
        .shut(lk[0].shut));
    task chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task t_start();
        repeat (40) if (lk[0].role !== RA) @(negedge i_clk);
        repeat (2) @(negedge i_clk);
        chk(lk[0].role, RA);
        chk(slot, 1'b0);
        chk(av, 1'b1);
        chk(ft[0], 1'b1);
        chk(ci[0], GS);
        chk(ai[0], RF);
        chk(en[0], 1'b0);
        btn = 1'b1;
        repeat (4) @(negedge i_clk);
        btn = 1'b0;
        repeat (20) if (en[0] !== 1'b1) @(negedge i_clk);
        @(negedge i_clk);
        chk(en[0], 1'b1);
        chk(hl, 1'b1);
        chk(ai[0], GS);
    endtask
    task t_change();
        flt[0] = 1'b1;
        repeat (40) if (lk[1].cod_xfer !== 1'b1) @(negedge i_clk);
        @(negedge i_clk);
        chk(lk[0].role, RM);
        chk(av, 1'b0);
        chk(ft[0], 1'b0);
        chk(cw[1], cfg);
        chk(ci[1], AF);
        chk(ai[1], AF);
        repeat (20) if (lk[1].role !== RA) @(negedge i_clk);
        chk(lk[1].role, RA);
        chk(dw[1], changeover_state_data);
        repeat (40) if (cx !== 1'b0) @(negedge i_clk);
        chk(lk[0].role, RB);
        chk(slot, 1'b1);
        flt[0] = 1'b0;
        @(negedge i_clk);
        chk(si[0], GS);
    endtask
    task t_revert();
        stp[0] = 1'b0;
        {swa[1], swb[1]} = 2'b00;
        repeat (40) if (lk[0].role !== RA) @(negedge i_clk);
        chk(lk[0].role, RA);
        repeat (60) if (cx !== 1'b0) @(negedge i_clk);
        chk(lk[0].role, RB);
        chk(lk[1].role, RA);
        chk(slot, 1'b1);
        {swa[1], swb[1], stp[0]} = 3'b111;
        repeat (20) if (cx !== 1'b1) @(negedge i_clk);
        repeat (60) if (cx !== 1'b0) @(negedge i_clk);
        chk(lk[0].role, RA);
    endtask
    task t_force();
        flt[1] = 1'b1;
        {swa[0], swb[0]} = 2'b00;
        repeat (40) if (lk[0].role !== RM) @(negedge i_clk);
        repeat (20) if (lk[0].role !== RA) @(negedge i_clk);
        chk(lk[0].role, RA);
        chk(lk[1].role, RB);
        chk(slot, 1'b0);
        btn = 1'b1;
        repeat (4) @(negedge i_clk);
        btn = 1'b0;
        repeat (40) if (lk[1].role !== RA) @(negedge i_clk);
        chk(lk[1].role, RA);
        chk(slot, 1'b1);
        flt[1] = 1'b0;
        {swa[0], swb[0]} = 2'b11;
        repeat (4) @(negedge i_clk);
        chk(lk[0].role, RB);
    endtask
    task t_shut();
        sd[0] = 1'b1;
        repeat (3) @(negedge i_clk);
        sd[0] = 1'b0;
        flt[1] = 1'b1;
        repeat (8) @(negedge i_clk);
        chk(hi[0][2], RS);
        chk(ai[0], RF);
        chk(ci[0], AF);
        chk(lk[0].shut, 1'b1);
        chk(lk[1].role, RA);
        chk(cx, 1'b0);
        flt[1] = 1'b0;
        seat[0] = 1'b0;
        repeat (4) @(negedge i_clk);
        seat[0] = 1'b1;
        repeat (4) @(negedge i_clk);
        chk(lk[0].shut, 1'b0);
        chk(hi[0][0], GS);
    endtask
    task summarize();
        $display("checks %0d errors %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        #1000000;
        bad_count++;
        summarize();
    end
    initial begin
        {i_rst_b, btn, flt, sd, slf} = '0;
        {ce, seat, swa, swb, stp} = '1;
        ty = 4'h5;
        pid = 4'h3;
        cfg = 8'hA5;
        changeover_state_data = 8'h3C;
        repeat (12) @(negedge i_clk);
        i_rst_b = 1'b1;
        t_start();
        t_change();
        t_revert();
        t_force();
        t_shut();
        summarize();
    end
endmodule
